/* File: verilog/usb_interface_machine_pkg.sv */
// Package with register map, field positions and reset values of the USB interface machine.
package usb_interface_machine_pkg;
  // Register offsets in the peripheral space.
  localparam logic [7:0] interface_reset_off = 8'h00;
  localparam logic [7:0] machine_control_off = 8'h04;
  localparam logic [7:0] device_address_off = 8'h08;
  localparam logic [7:0] functional_control_off = 8'h0c;
  localparam logic [7:0] otg_control_off = 8'h10;
  localparam logic [7:0] otg_status_flags_off = 8'h14;
  localparam logic [7:0] serial_control_off = 8'h18;
  localparam logic [7:0] line_event_flags_off = 8'h1c;
  localparam logic [7:0] flag_persistence_off = 8'h20;
  localparam logic [7:0] event_port_masks_off = 8'h24;
  localparam logic [7:0] frame_counter_off = 8'h28;
  localparam logic [7:0] last_packet_id_off = 8'h2c;
  localparam logic [7:0] last_endpoint_off = 8'h30;
  localparam logic [7:0] endpoint_special_mask_off = 8'h34;
  localparam logic [7:0] otg_flag_mask_off = 8'h38;

  // Field widths.
  localparam int flag_w = 7;
  localparam int otg_ctl_w = 8;
  localparam int otg_sts_w = 6;
  localparam int addr_w = 7;
  localparam int sof_w = 11;
  localparam int pid_w = 4;
  localparam int ep_w = 4;
  localparam int ep_count = 16;
  localparam int mask_w = 8;
  localparam int port_count = 4;

  // Reset values and write masks.
  localparam logic [2:0] opmode_reset = 3'h1;
  localparam logic [4:0] functional_reset = 5'h07;
  localparam logic [3:0] serial_ctl_reset = 4'h2;
  localparam logic [7:0] otg_ctl_otg_mask = 8'hdf;
  localparam logic [7:0] machine_ctl_mask = 8'hf7;

  // Signal flag bit positions.
  localparam int flag_token = 6;
  localparam int flag_se0 = 5;
  localparam int flag_k = 4;
  localparam int flag_j = 3;
  localparam int flag_crc16 = 2;
  localparam int flag_rxactive = 1;
  localparam int flag_rxerror = 0;

  // Special endpoint marker ORed onto the receive port.
  localparam logic [4:0] ep_special_or = 5'h10;

  // Line state codes.
  localparam logic [1:0] line_se0 = 2'h0;
  localparam logic [1:0] line_j = 2'h1;
  localparam logic [1:0] line_k = 2'h2;
endpackage

/* File: verilog/usb_reg_port_if.sv */
// Interface carrying register access signals between the top and its decoder.
`timescale 1ns/1ps
interface usb_reg_port_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic sel_reset;
  logic sel_func;
  logic sel_otg;
  logic sel_serial;
  logic sel_flags;
  logic sel_persist;
  logic sel_masks;
  logic sel_sof;
  logic sel_epmask;
  logic sel_otgmask;
  logic sel_ctl;
  logic sel_addr;
  logic mapped;
  modport decoder (input wr_en, rd_en, addr, output sel_reset, sel_func, sel_otg,
    sel_serial, sel_flags, sel_persist, sel_masks, sel_sof, sel_epmask, sel_otgmask,
    sel_ctl, sel_addr, mapped);
  modport core (output wr_en, rd_en, addr, wdata, input sel_reset, sel_func, sel_otg,
    sel_serial, sel_flags, sel_persist, sel_masks, sel_sof, sel_epmask, sel_otgmask,
    sel_ctl, sel_addr, mapped);
endinterface

/* File: verilog/usb_reg_decoder.sv */
// Address decoder turning a register offset into write selects.
`timescale 1ns/1ps
module usb_reg_decoder (
  usb_reg_port_if.decoder bus // Register access signals.
);
  // Combinational select of each writable register.
  always_comb begin
    bus.sel_reset = bus.wr_en && bus.addr == usb_interface_machine_pkg::interface_reset_off;
    bus.sel_ctl = bus.wr_en && bus.addr == usb_interface_machine_pkg::machine_control_off;
    bus.sel_addr = bus.wr_en && bus.addr == usb_interface_machine_pkg::device_address_off;
    bus.sel_func = bus.wr_en && bus.addr == usb_interface_machine_pkg::functional_control_off;
    bus.sel_otg = bus.wr_en && bus.addr == usb_interface_machine_pkg::otg_control_off;
    bus.sel_serial = bus.wr_en && bus.addr == usb_interface_machine_pkg::serial_control_off;
    bus.sel_flags = bus.wr_en && bus.addr == usb_interface_machine_pkg::line_event_flags_off;
    bus.sel_persist = bus.wr_en && bus.addr == usb_interface_machine_pkg::flag_persistence_off;
    bus.sel_masks = bus.wr_en && bus.addr == usb_interface_machine_pkg::event_port_masks_off;
    bus.sel_sof = bus.wr_en && bus.addr == usb_interface_machine_pkg::frame_counter_off;
    bus.sel_epmask = bus.wr_en
      && bus.addr == usb_interface_machine_pkg::endpoint_special_mask_off;
    bus.sel_otgmask = bus.wr_en && bus.addr == usb_interface_machine_pkg::otg_flag_mask_off;
    bus.mapped = bus.rd_en && bus.addr[1:0] == 2'h0
      && bus.addr <= usb_interface_machine_pkg::otg_flag_mask_off;
  end
endmodule // usb_reg_decoder

/* File: verilog/usb_interface_machine.sv */
// Register and flag logic of the USB interface machine facing a UTMI+ transceiver.
// Functional notes
// RQ1: Opmode field bits 4:2 drives OPMODE.
// RQ2: Bits 1 and 0 drive TERMSELECT, XCVRSELECT.
// RQ3: OTG control bits drive VBUS and pull outputs.
// RQ4: OTG flags read live transceiver status.
// RQ5: Serial register reads RXRCV, RXDM, RXDP.
// RQ6: Serial register drives TXSE0, TXDATA, TXENABLE_N, FSLSSERIAL.
// RQ7: Flag 6 set on valid addressed token.
// RQ8: Flags 5,4,3 set on SE0, K, J.
// RQ9: Flag 2 set on CRC16 failure.
// RQ10: Flags 1,0 follow RXACTIVE, RXERROR.
// RQ11: Non-sticky flags clear on next packet.
// RQ12: Sticky flags hold until written one.
// RQ13: Four masks OR flags onto event ports.
// RQ14: Eleven-bit read-write frame counter.
// RQ15: Last received PID captured read-only.
// RQ16: Last endpoint and valid bit read-only.
// RQ17: Special endpoints presented ORed with 0x10.
// RQ18: Access only by 32-bit reads and writes.
// RQ19: Any write to reset register clears state.
// RQ20: Only packets for device address pass; code gates tokens and SOF only, not PID capture or the CRC16 flag.
// RQ21: Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
module usb_interface_machine (
  input wire logic ref_clk, // System clock, 40 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic reg_wr, // Peripheral 32-bit write strobe.
  input wire logic reg_rd, // Peripheral 32-bit read strobe.
  input wire logic [7:0] reg_addr, // Register byte offset.
  input wire logic [31:0] reg_wdata, // Write data.
  output logic [31:0] reg_rdata, // Read data, registered.
  output logic reg_rvalid, // Read data valid pulse.
  output logic [2:0] utmi_opmode, // UTMI+ OPMODE.
  output logic utmi_termselect, // UTMI+ TERMSELECT.
  output logic utmi_xcvrselect, // UTMI+ XCVRSELECT.
  output logic external_vbus_indicator_select, // External VBUS indicator select.
  output logic external_vbus_drive, // External VBUS drive.
  output logic utmi_chrgvbus, // UTMI+ CHRGVBUS.
  output logic utmi_dischrgvbus, // UTMI+ DISCHRGVBUS.
  output logic utmi_dmpulldown, // UTMI+ DMPULLDOWN.
  output logic utmi_dppulldown, // UTMI+ DPPULLDOWN.
  output logic utmi_idpullup, // UTMI+ IDPULLUP.
  input wire logic utmi_bvalid, // UTMI+ BVALID.
  input wire logic utmi_idgnd, // UTMI+ IDGND.
  input wire logic utmi_hostdis, // UTMI+ HOSTDIS.
  input wire logic utmi_vbusvld, // UTMI+ VBUSVLD.
  input wire logic utmi_sessvld, // UTMI+ SESSVLD.
  input wire logic utmi_sessend, // UTMI+ SESSEND.
  input wire logic utmi_rxrcv, // UTMI+ RXRCV.
  input wire logic utmi_rxdm, // UTMI+ RXDM.
  input wire logic utmi_rxdp, // UTMI+ RXDP.
  output logic utmi_txse0, // UTMI+ TXSE0.
  output logic utmi_txdata, // UTMI+ TXDATA.
  output logic utmi_txenable_n, // UTMI+ TXENABLE, active low.
  output logic utmi_fslsserial, // UTMI+ FSLSSERIAL.
  input wire logic [1:0] utmi_linestate, // UTMI+ line state.
  input wire logic utmi_rxactive, // UTMI+ RXACTIVE.
  input wire logic utmi_rxerror, // UTMI+ RXERROR.
  input wire logic pkt_start, // Pulse: a new packet begins.
  input wire logic token_valid, // Pulse: token decoded with CRC5 and PID good.
  input wire logic [6:0] token_addr, // Address field of that token.
  input wire logic [3:0] token_endp, // Endpoint field of that token.
  input wire logic pid_valid, // Pulse: packet identifier received.
  input wire logic [3:0] pid_value, // Received packet identifier.
  input wire logic crc16_fail, // Pulse: data packet failed CRC16.
  input wire logic sof_valid, // Pulse: start-of-frame received.
  input wire logic [10:0] sof_number, // Frame number of that SOF.
  output logic [3:0] event_ports, // Event ports; bit 0 is event_port_a.
  output logic [4:0] rx_endpoint, // Endpoint for the receive port.
  output logic rx_endpoint_valid // Receive port endpoint valid pulse.
);
  typedef struct packed {
    logic [7:0] machine_ctl;
    logic [6:0] dev_addr;
    logic [4:0] functional;
    logic [7:0] otg_ctl;
    logic [3:0] serial_ctl;
    logic [6:0] flags;
    logic [6:0] persist;
    logic [31:0] masks;
    logic [10:0] sof;
    logic [3:0] pid;
    logic [3:0] endp;
    logic endp_valid;
    logic [15:0] ep_mask;
    logic [31:0] otg_mask;
    logic [31:0] rdata;
    logic rvalid;
    logic [4:0] rx_ep;
    logic rx_ep_valid;
    logic [3:0] ports;
  } state_t;

  state_t state_reg;
  state_t state_next;
  usb_reg_port_if bus ();

  // Returns true when a flag mask selects any raised flag.
  function automatic logic mask_hit(input logic [7:0] mask, input logic [6:0] flags);
    mask_hit = |(mask[6:0] & flags);
  endfunction

  assign bus.wr_en = reg_wr; // RQ18
  assign bus.rd_en = reg_rd;
  assign bus.addr = reg_addr;
  assign bus.wdata = reg_wdata;

  usb_reg_decoder decoder (
    .bus(bus)
  );

  logic addr_match;
  logic [6:0] flag_set;
  logic [6:0] flag_level;
  logic [6:0] flags_new;
  logic [3:0] port_hit;
  logic [31:0] read_word;

  // Accept tokens and SOF only when the token address equals the device address.
  assign addr_match = token_addr == state_reg.dev_addr; // RQ20

  // Event sources for each flag position.
  always_comb begin
    flag_set = '0;
    flag_set[usb_interface_machine_pkg::flag_token] = token_valid && addr_match; // RQ7
    flag_set[usb_interface_machine_pkg::flag_se0] =
      utmi_linestate == usb_interface_machine_pkg::line_se0; // RQ8
    flag_set[usb_interface_machine_pkg::flag_k] =
      utmi_linestate == usb_interface_machine_pkg::line_k;
    flag_set[usb_interface_machine_pkg::flag_j] =
      utmi_linestate == usb_interface_machine_pkg::line_j;
    flag_set[usb_interface_machine_pkg::flag_crc16] = crc16_fail; // RQ9
    flag_level = '0;
    flag_level[usb_interface_machine_pkg::flag_rxactive] = utmi_rxactive; // RQ10
    flag_level[usb_interface_machine_pkg::flag_rxerror] = utmi_rxerror;
    // New packet clears normal flags, writing 1 clears sticky ones, set wins.
    flags_new = state_reg.flags;
    for (int i = 0; i < usb_interface_machine_pkg::flag_w; i++) begin
      if (state_reg.persist[i]) begin
        if (bus.sel_flags && reg_wdata[i]) begin
          flags_new[i] = 1'b0; // RQ12
        end
        if (flag_set[i] || flag_level[i]) begin
          flags_new[i] = 1'b1;
        end
      end else begin
        if (pkt_start) begin
          flags_new[i] = 1'b0; // RQ11
        end
        if (flag_set[i]) begin
          flags_new[i] = 1'b1;
        end
        if (i <= usb_interface_machine_pkg::flag_rxactive) begin
          flags_new[i] = flag_level[i]; // RQ10
        end
      end
    end
  end

  // One mask comparison per event port.
  genvar gi;
  generate
    for (gi = 0; gi < usb_interface_machine_pkg::port_count; gi++) begin : g_port
      assign port_hit[gi] = mask_hit(state_reg.masks[gi*8 +: 8], flags_new); // RQ13
    end
  endgenerate

  // Read multiplexer; reserved bits read as zero.
  always_comb begin
    read_word = '0;
    case (reg_addr)
      usb_interface_machine_pkg::machine_control_off: read_word[7:0] = state_reg.machine_ctl;
      usb_interface_machine_pkg::device_address_off: read_word[6:0] = state_reg.dev_addr;
      usb_interface_machine_pkg::functional_control_off: read_word[4:0] = state_reg.functional;
      usb_interface_machine_pkg::otg_control_off: read_word[7:0] = state_reg.otg_ctl;
      usb_interface_machine_pkg::otg_status_flags_off: read_word[5:0] = {utmi_bvalid,
        utmi_idgnd, utmi_hostdis, utmi_vbusvld, utmi_sessvld, utmi_sessend}; // RQ4
      usb_interface_machine_pkg::serial_control_off: read_word[6:0] = {utmi_rxrcv, utmi_rxdm,
        utmi_rxdp, state_reg.serial_ctl}; // RQ5
      usb_interface_machine_pkg::line_event_flags_off: read_word[6:0] = state_reg.flags;
      usb_interface_machine_pkg::flag_persistence_off: read_word[6:0] = state_reg.persist;
      usb_interface_machine_pkg::event_port_masks_off: read_word = state_reg.masks;
      usb_interface_machine_pkg::frame_counter_off: read_word[10:0] = state_reg.sof;
      usb_interface_machine_pkg::last_packet_id_off: read_word[3:0] = state_reg.pid;
      usb_interface_machine_pkg::last_endpoint_off: read_word[4:0] = {state_reg.endp_valid,
        state_reg.endp}; // RQ16
      usb_interface_machine_pkg::endpoint_special_mask_off: read_word[15:0] = state_reg.ep_mask;
      usb_interface_machine_pkg::otg_flag_mask_off: read_word = state_reg.otg_mask;
      default: read_word = '0; // RQ21
    endcase
  end

  // Next-state logic for all registers and flags.
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = reg_rd;
    state_next.rdata = reg_rd ? (bus.mapped ? read_word : '0) : state_reg.rdata; // RQ21
    state_next.rx_ep_valid = 1'b0;

    // Software writes; reserved bits are dropped by the field widths and the control masks.
    if (bus.sel_ctl) begin
      state_next.machine_ctl = reg_wdata[7:0] & usb_interface_machine_pkg::machine_ctl_mask;
    end
    if (bus.sel_addr) begin
      state_next.dev_addr = reg_wdata[6:0];
    end
    if (bus.sel_func) begin
      state_next.functional = reg_wdata[4:0]; // RQ1 RQ2
    end
    if (bus.sel_otg) begin
      state_next.otg_ctl = reg_wdata[7:0] & usb_interface_machine_pkg::otg_ctl_otg_mask; // RQ3
    end
    if (bus.sel_serial) begin
      state_next.serial_ctl = reg_wdata[3:0]; // RQ6
    end
    if (bus.sel_persist) begin
      state_next.persist = reg_wdata[6:0]; // RQ12
    end
    if (bus.sel_masks) begin
      state_next.masks = reg_wdata; // RQ13
    end
    if (bus.sel_epmask) begin
      state_next.ep_mask = reg_wdata[15:0];
    end
    if (bus.sel_otgmask) begin
      state_next.otg_mask = reg_wdata;
    end

    // Frame counter: software write, overwritten by a received SOF when the token address equals the device address.
    if (bus.sel_sof) begin
      state_next.sof = reg_wdata[10:0]; // RQ14
    end
    if (sof_valid && addr_match) begin
      state_next.sof = sof_number;
    end

    // Flags come from the event logic, which also feeds the event ports.
    state_next.flags = flags_new;

    // Packet identifier capture.
    if (pid_valid) begin
      state_next.pid = pid_value; // RQ15
    end

    // Endpoint capture and receive port presentation.
    if (token_valid && addr_match) begin
      state_next.endp = token_endp; // RQ16
      state_next.endp_valid = 1'b1;
      state_next.rx_ep_valid = 1'b1;
      state_next.rx_ep = state_reg.ep_mask[token_endp]
        ? ({1'b0, token_endp} | usb_interface_machine_pkg::ep_special_or)
        : {1'b0, token_endp}; // RQ17
    end

    state_next.ports = port_hit;

    // A write to the reset register restores all machine state.
    if (bus.sel_reset) begin
      state_next = '0; // RQ19
      state_next.functional = usb_interface_machine_pkg::functional_reset;
      state_next.serial_ctl = usb_interface_machine_pkg::serial_ctl_reset;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.functional <= usb_interface_machine_pkg::functional_reset;
      state_reg.serial_ctl <= usb_interface_machine_pkg::serial_ctl_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign utmi_opmode = state_reg.functional[4:2]; // RQ1
  assign utmi_termselect = state_reg.functional[1]; // RQ2
  assign utmi_xcvrselect = state_reg.functional[0];
  assign external_vbus_indicator_select = state_reg.otg_ctl[7]; // RQ3
  assign external_vbus_drive = state_reg.otg_ctl[6];
  assign utmi_chrgvbus = state_reg.otg_ctl[4];
  assign utmi_dischrgvbus = state_reg.otg_ctl[3];
  assign utmi_dmpulldown = state_reg.otg_ctl[2];
  assign utmi_dppulldown = state_reg.otg_ctl[1];
  assign utmi_idpullup = state_reg.otg_ctl[0];
  assign utmi_txse0 = state_reg.serial_ctl[3]; // RQ6
  assign utmi_txdata = state_reg.serial_ctl[2];
  assign utmi_txenable_n = state_reg.serial_ctl[1];
  assign utmi_fslsserial = state_reg.serial_ctl[0];
  assign event_ports = state_reg.ports; // RQ13
  assign rx_endpoint = state_reg.rx_ep;
  assign rx_endpoint_valid = state_reg.rx_ep_valid;
endmodule // usb_interface_machine

/* File: tb/usb_machine_properties.sv */
// Checker of register read timing and register-driven transceiver controls.
`timescale 1ns/1ps
module usb_machine_checker (
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_addr, // Register offset.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire logic reg_rvalid, // Read data valid.
  input wire logic [2:0] utmi_opmode, // Operating mode.
  input wire logic utmi_termselect, // Termination select.
  input wire logic utmi_txenable_n, // Transmit enable, active low.
  input wire logic utmi_bvalid, // B-session valid.
  input wire logic utmi_rxdp, // Receiver D+ level.
  input wire logic token_valid, // Token pulse.
  input wire logic [3:0] token_endp, // Token endpoint.
  input wire logic [4:0] rx_endpoint, // Receive port endpoint.
  input wire logic rx_endpoint_valid // Receive port pulse.
);
  // All checks run on the system clock and rest while reset is low.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Each property ties an output or read result to the access that caused it.
  property p_read_answer;
    reg_rd |=> reg_rvalid ##1 (!reg_rvalid || $past(reg_rd));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
  property p_opmode;
    reg_wr && reg_addr == 8'h0c |=> utmi_opmode == $past(reg_wdata[4:2]);
  endproperty
  a_opmode: assert property (p_opmode) else $error("opmode not from write");
  property p_termselect;
    reg_wr && reg_addr == 8'h0c |=> utmi_termselect == $past(reg_wdata[1]);
  endproperty
  a_termselect: assert property (p_termselect) else $error("termselect not from write");
  property p_otg_status;
    reg_rd && reg_addr == 8'h14 |=> reg_rdata[5] == $past(utmi_bvalid);
  endproperty
  a_otg_status: assert property (p_otg_status) else $error("bvalid not read live");
  property p_rx_lines;
    reg_rd && reg_addr == 8'h18 |=> reg_rdata[4] == $past(utmi_rxdp);
  endproperty
  a_rx_lines: assert property (p_rx_lines) else $error("rxdp not read live");
  property p_tx_enable;
    reg_wr && reg_addr == 8'h18 |=> utmi_txenable_n == $past(reg_wdata[1]);
  endproperty
  a_tx_enable: assert property (p_tx_enable) else $error("tx enable not from write");
  property p_machine_reset;
    reg_wr && reg_addr == 8'h00 |-> ##[1:2] (utmi_opmode == 3'h1 && utmi_txenable_n);
  endproperty
  a_machine_reset: assert property (p_machine_reset) else $error("soft reset missed");
  property p_endpoint;
    rx_endpoint_valid |-> $past(token_valid) && rx_endpoint[3:0] == $past(token_endp);
  endproperty
  a_endpoint: assert property (p_endpoint) else $error("endpoint not from token");
  // Main scenarios reached.
  c_special: cover property (rx_endpoint_valid && rx_endpoint[4]);
  c_soft_reset: cover property (reg_wr && reg_addr == 8'h00);
  c_status_read: cover property (reg_rd && reg_addr == 8'h14 ##1 reg_rvalid);
endmodule // usb_machine_checker
// Attach the checker to every instance of the machine.
bind usb_interface_machine usb_machine_checker chk (.ref_clk, .reset_n, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .utmi_opmode, .utmi_termselect,
  .utmi_txenable_n, .utmi_bvalid, .utmi_rxdp, .token_valid, .token_endp, .rx_endpoint,
  .rx_endpoint_valid);

/* File: tb/utmi_xcvr_model.sv */
// Behavioural transceiver model feeding line and status pins of the interface machine.
`timescale 1ns/1ps
module utmi_xcvr_model (
  input wire logic [1:0] line_set, // Bus state while the device is silent.
  input wire logic [5:0] sts_set, // Session and ID status to present.
  input wire logic [2:0] rx_set, // Receiver levels to present.
  input wire logic utmi_txse0, // Device drives SE0.
  input wire logic utmi_txdata, // Device transmit data.
  input wire logic utmi_txenable_n, // Device transmit enable, active low.
  output logic [1:0] utmi_linestate, // Line state code.
  output logic [5:0] otg_sts, // BVALID down to SESSEND.
  output logic [2:0] rx_lines // RXRCV, RXDM, RXDP.
);
  // While the device transmits, the line state echoes its own drive.
  assign utmi_linestate = !utmi_txenable_n ? (utmi_txse0 ? 2'h0 : (utmi_txdata ? 2'h1 : 2'h2))
    : line_set;
  // Status and receiver levels follow the settings.
  assign otg_sts = sts_set;
  assign rx_lines = rx_set;
endmodule // utmi_xcvr_model

/* File: tb/usb_phy_interface_control_regs_bench.sv */
// Self-checking bench for the USB interface machine registers and event logic.
`timescale 1ns/1ps
module usb_phy_interface_control_regs_bench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_t;
  logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, pkt_start = 0, token_valid = 0;
  logic pid_valid = 0, crc16_fail = 0, sof_valid = 0, utmi_rxactive = 0, utmi_rxerror = 0;
  logic reg_rvalid, utmi_txse0, utmi_txdata, utmi_txenable_n, rx_endpoint_valid, fsls_pin;
  logic [1:0] sel_pins;
  logic [6:0] otg_pins;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [6:0] token_addr = 7'h00;
  logic [3:0] token_endp = 4'h0, pid_value = 4'h0, event_ports;
  logic [10:0] sof_number = 11'h000;
  logic [1:0] line_set = 2'h3, utmi_linestate;
  logic [5:0] sts_set = 6'h00, otg_sts;
  logic [2:0] rx_set = 3'h0, rx_lines, utmi_opmode;
  logic [4:0] rx_endpoint;
  wire [15:0] pins = {utmi_opmode, sel_pins, otg_pins, utmi_txse0, utmi_txdata,
    utmi_txenable_n, fsls_pin};
  logic [1:0] lcode [3] = '{2'h0, 2'h2, 2'h1};
  int lbit [3] = '{5, 4, 3};
  int n_errors = 0, samples_checked = 0, cycles = 0;
  row_t rows [10] = '{
    '{8'h0c, 32'hffff_ffff, 32'h0000_001f}, '{8'h10, 32'hffff_ffff, 32'h0000_00df},
    '{8'h18, 32'hffff_fffa, 32'h0000_000a}, '{8'h20, 32'hffff_ffff, 32'h0000_007f},
    '{8'h24, 32'h7f7f_7f7f, 32'h7f7f_7f7f}, '{8'h28, 32'hffff_ffff, 32'h0000_07ff},
    '{8'h2c, 32'hffff_ffff, 32'h0000_0000}, '{8'h34, 32'hffff_ffff, 32'h0000_ffff},
    '{8'h38, 32'ha5a5_5a5a, 32'ha5a5_5a5a}, '{8'h44, 32'hffff_ffff, 32'h0000_0000}};
  // Design and transceiver model.
  usb_interface_machine DUT (.ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .utmi_opmode, .utmi_termselect(sel_pins[1]),
    .utmi_xcvrselect(sel_pins[0]), .external_vbus_indicator_select(otg_pins[6]),
    .external_vbus_drive(otg_pins[5]), .utmi_chrgvbus(otg_pins[4]),
    .utmi_dischrgvbus(otg_pins[3]), .utmi_dmpulldown(otg_pins[2]),
    .utmi_dppulldown(otg_pins[1]), .utmi_idpullup(otg_pins[0]),
    .utmi_bvalid(otg_sts[5]), .utmi_idgnd(otg_sts[4]), .utmi_hostdis(otg_sts[3]),
    .utmi_vbusvld(otg_sts[2]), .utmi_sessvld(otg_sts[1]), .utmi_sessend(otg_sts[0]),
    .utmi_rxrcv(rx_lines[2]), .utmi_rxdm(rx_lines[1]), .utmi_rxdp(rx_lines[0]),
    .utmi_txse0, .utmi_txdata, .utmi_txenable_n, .utmi_fslsserial(fsls_pin), .utmi_linestate,
    .utmi_rxactive, .utmi_rxerror, .pkt_start, .token_valid, .token_addr, .token_endp,
    .pid_valid, .pid_value, .crc16_fail, .sof_valid, .sof_number, .event_ports,
    .rx_endpoint, .rx_endpoint_valid);
  utmi_xcvr_model xcvr (.line_set, .sts_set, .rx_set, .utmi_txse0, .utmi_txdata,
    .utmi_txenable_n, .utmi_linestate, .otg_sts, .rx_lines);
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Cuts a hang short far beyond the roughly 120 cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Inputs change a fixed 2 ns after the rising edge.
  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Accesses keep an idle cycle after the strobe so it is never re-raised in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd = 1;
    reg_addr = a;
    tick();
    reg_rd = 0;
    chk(32'(reg_rvalid), 32'h0000_0001);
    chk(reg_rdata, exp);
    tick();
  endtask
  task automatic pkt();
    pkt_start = 1;
    tick();
    pkt_start = 0;
    tick();
  endtask
  // Token pulse; the receive port answers on the taking edge.
  task automatic tok(input logic [6:0] a, input logic [3:0] e, input logic v,
    input logic [4:0] q);
    token_valid = 1;
    token_addr = a;
    token_endp = e;
    tick();
    token_valid = 0;
    chk(32'(rx_endpoint_valid), 32'(v));
    if (v) begin
      chk(32'(rx_endpoint), 32'(q));
    end
    tick();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: reset, register table, then hand-written cases.
  initial begin
    repeat (10) @(posedge ref_clk);
    #2;
    chk(32'({event_ports, reg_rvalid, rx_endpoint_valid, pins}), 32'h0000_3802);
    reset_n = 1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    chk(32'(pins), 32'h0000_fffa);
    $display("test table done");
    wr(8'h00, 32'h0000_0000);
    chk(32'(utmi_opmode), 32'h0000_0001);
    chk(32'(pins), 32'h0000_3802);
    rd(8'h0c, 32'h0000_0007);
    rd(8'h18, 32'h0000_0002);
    rd(8'h24, 32'h0000_0000);
    $display("test machine reset done");
    sts_set = 6'h2a;
    rx_set = 3'h5;
    tick();
    rd(8'h14, 32'h0000_002a);
    rd(8'h18, 32'h0000_0052);
    $display("test status done");
    for (int i = 0; i < 3; i++) begin
      pkt();
      line_set = lcode[i];
      tick();
      line_set = 2'h3;
      rd(8'h1c, 32'h0000_0001 << lbit[i]);
    end
    pkt();
    crc16_fail = 1;
    utmi_rxactive = 1;
    tick();
    crc16_fail = 0;
    rd(8'h1c, 32'h0000_0006);
    utmi_rxactive = 0;
    utmi_rxerror = 1;
    tick();
    rd(8'h1c, 32'h0000_0005);
    utmi_rxerror = 0;
    $display("test line flags done");
    wr(8'h08, 32'h0000_0005);
    wr(8'h34, 32'h0000_0008);
    wr(8'h24, 32'h4000_4040);
    tok(7'h05, 4'h3, 1'b1, 5'h13);
    chk(32'(event_ports), 32'h0000_000b);
    rd(8'h30, 32'h0000_0013);
    tok(7'h05, 4'h2, 1'b1, 5'h02);
    tok(7'h06, 4'h2, 1'b0, 5'h00);
    pkt();
    chk(32'(event_ports), 32'h0000_0000);
    wr(8'h20, 32'h0000_0040);
    tok(7'h05, 4'h3, 1'b1, 5'h13);
    pkt();
    chk(32'(event_ports), 32'h0000_000b);
    wr(8'h1c, 32'h0000_0040);
    chk(32'(event_ports), 32'h0000_0000);
    $display("test token and events done");
    pid_valid = 1;
    pid_value = 4'ha;
    sof_valid = 1;
    sof_number = 11'h5a5;
    token_addr = 7'h05;
    tick();
    pid_valid = 0;
    sof_valid = 0;
    rd(8'h2c, 32'h0000_000a);
    rd(8'h28, 32'h0000_05a5);
    $display("test packet id and frame done");
    wr(8'h10, 32'h0000_00ff);
    reset_n = 0;
    tick();
    reset_n = 1;
    chk(32'(pins), 32'h0000_3802);
    rd(8'h28, 32'h0000_0000);
    $display("test hardware reset done");
    report_and_stop();
  end
endmodule // usb_phy_interface_control_regs_bench
